// file: logic/slot_ctl_pkg.sv
// constants for the hot-plug slot control block
package slot_ctl_pkg;
   // register offsets
   localparam logic [11:0] CAP_OFS = 12'h054;
   localparam logic [11:0] CTL_OFS = 12'h058;
   localparam logic [11:0] STS_OFS = 12'h05A;
   localparam logic [11:0] MASK_OFS = 12'h0A0;
   // slot_control field positions
   localparam int BTN_EN = 0;
   localparam int PF_EN = 1;
   localparam int LATCH_EN = 2;
   localparam int PRES_EN = 3;
   localparam int CC_EN = 4;
   localparam int MASTER_EN = 5;
   localparam int ATTN_LO = 6;
   localparam int PIND_LO = 8;
   localparam int PWR_CTL = 10;
   localparam int ILOCK_CTL = 11;
   localparam int LINK_EN = 12;
   // slot_capabilities field positions
   localparam int CAP_BTN = 0;
   localparam int CAP_PWRCTL = 1;
   localparam int CAP_LATCH = 2;
   localparam int CAP_ATTN = 3;
   localparam int CAP_PIND = 4;
   localparam int CAP_HPC = 6;
   localparam int CAP_ILOCK = 17;
   // slot status field positions
   localparam int ST_BTN = 0;
   localparam int ST_PF = 1;
   localparam int ST_LATCH = 2;
   localparam int ST_PRES = 3;
   localparam int ST_CC = 4;
   localparam int ST_LATCH_ST = 5;
   localparam int ST_PRES_ST = 6;
   localparam int ST_ILOCK_ST = 7;
   localparam int ST_LINK = 8;
   // values after reset
   localparam logic [1:0] ATTN_RST = 2'h3;
   localparam logic [1:0] PIND_RST = 2'h1;
   localparam logic [31:0] CAP_RST = 32'h0000_0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] STS_RST = 16'h0000;
   // writable capability bits and sticky status bits
   localparam logic [31:0] CAP_WMASK = 32'h0002_005F;
   localparam logic [15:0] STS_STICKY = 16'h011F;
endpackage

// file: logic/sync_edge.sv
// two-flop synchroniser with rise and change detection per bit
`timescale 1ns/10ps
module sync_edge #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // asynchronous levels in
   input wire logic [W-1:0] d_in,
   // synchronised level and edges out
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] change
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] last_r;

   // meta_r feeds only sync_r
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
         last_r <= '0;
      end else begin
         meta_r <= d_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~last_r;
   assign change = sync_r ^ last_r;
endmodule

// file: logic/slot_ctl.sv
// hot-plug slot control register bank of a downstream port
// Function
// - button event enable bit 0 lets a button press raise interrupt or wake
// - power fault enable bit 1 lets a power fault raise interrupt or wake
// - latch change enable bit 2 lets latch sensor change raise interrupt/wake
// - presence change enable bit 3 lets presence change raise interrupt/wake
// - command done enable bit 4 raises interrupt only, never wake
// - master enable bit 5 gates hp_irq; irq follows status and mask register only
// - fields without their capability read zero and ignore writes
// - attention indicator 7:6 resets off, write sets it, read returns it
// - attention indicator reads zero when its present bit is clear
// - power indicator 9:8 resets on, same coding, write sets, read returns
// - power indicator reads zero when its present bit is clear
// - on the upstream port power indicator writes reach no indicator
// - bit 10 sets slot power, zero on, one off, read returns it
// - interlock bit 11 reads zero; writing one toggles the interlock
// - link active change enable bit 12 lets it raise interrupt or wake
// - slot_control writes during a running command fold into one repeat command; done flag after all actions
// - button pressed flag sets on press, cleared by writing one
// - capability bit 3 tells whether an attention indicator exists
`timescale 1ns/10ps
module slot_ctl #(
   parameter bit UPSTREAM = 1'b0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // slot sensors, asynchronous
   input wire logic btn_in,
   input wire logic pwr_fault_in,
   input wire logic latch_open_in,
   input wire logic present_in,
   input wire logic ilock_engaged_in,
   input wire logic link_up_in,
   input wire logic act_ack_in,
   // slot controls
   output logic [1:0] attention_indicator_ctl,
   output logic [1:0] power_indicator_ctl,
   output logic slot_power_ctl,
   output logic interlock_toggle_ctl,
   output logic act_req,
   // interrupts and wake
   output logic hp_irq,
   output logic wake,
   output logic irq
);
   typedef enum logic [2:0] {
      CMD_IDLE = 3'b001,
      CMD_REQ = 3'b010,
      CMD_DROP = 3'b100
   } cmd_state_t;

   cmd_state_t cmd_r;
   cmd_state_t cmd_nxt;
   logic [31:0] slot_capabilities_r;
   logic [12:0] ctl_r;
   logic [15:0] sts_r;
   logic [15:0] mask_r;
   logic [1:0] attn_r;
   logic [1:0] pind_r;
   logic pwr_r;
   logic ilock_r;
   logic req_r;
   logic pend_r;
   logic hp_irq_r;
   logic wake_r;
   logic irq_r;
   logic [31:0] rdata_r;
   logic [6:0] lvl;
   logic [6:0] rise;
   logic [6:0] chg;
   logic [15:0] ctl_view;
   logic [15:0] sts_view;
   logic [15:0] sts_set;
   logic [15:0] evt_en;
   logic [12:0] ctl_wmask;
   logic ctl_wr;
   logic cc_set;

   // bit order: ack, link, interlock, presence, latch, fault, button
   sync_edge #(.W(7)) u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .d_in({act_ack_in, link_up_in, ilock_engaged_in, present_in,
             latch_open_in, pwr_fault_in, btn_in}),
      .level(lvl),
      .rise(rise),
      .change(chg)
   );

   assign ctl_wr = wr && (addr == slot_ctl_pkg::CTL_OFS);

   // a field whose capability is absent takes no write
   always_comb begin
      ctl_wmask = 13'h1000;
      ctl_wmask[slot_ctl_pkg::BTN_EN] =
         slot_capabilities_r[slot_ctl_pkg::CAP_BTN];
      ctl_wmask[slot_ctl_pkg::PF_EN] =
         slot_capabilities_r[slot_ctl_pkg::CAP_PWRCTL];
      ctl_wmask[slot_ctl_pkg::LATCH_EN] =
         slot_capabilities_r[slot_ctl_pkg::CAP_LATCH];
      ctl_wmask[slot_ctl_pkg::PRES_EN] =
         slot_capabilities_r[slot_ctl_pkg::CAP_HPC];
      ctl_wmask[slot_ctl_pkg::CC_EN] =
         slot_capabilities_r[slot_ctl_pkg::CAP_HPC];
      ctl_wmask[slot_ctl_pkg::MASTER_EN] =
         slot_capabilities_r[slot_ctl_pkg::CAP_HPC];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         slot_capabilities_r <= slot_ctl_pkg::CAP_RST;
      end else if (wr && addr == slot_ctl_pkg::CAP_OFS) begin
         slot_capabilities_r <= wdata & slot_ctl_pkg::CAP_WMASK;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= '0;
      end else if (ctl_wr) begin
         ctl_r <= (wdata[12:0] & ctl_wmask) | (ctl_r & ~ctl_wmask);
      end else begin
         ctl_r <= ctl_r & ctl_wmask;
      end
   end

   // indicator, power and interlock state driven toward the slot
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         attn_r <= slot_ctl_pkg::ATTN_RST;
         pind_r <= slot_ctl_pkg::PIND_RST;
         pwr_r <= 1'b0;
         ilock_r <= 1'b0;
      end else begin
         ilock_r <= 1'b0;
         if (ctl_wr) begin
            if (slot_capabilities_r[slot_ctl_pkg::CAP_ATTN])
               attn_r <= wdata[slot_ctl_pkg::ATTN_LO +: 2];
            if (slot_capabilities_r[slot_ctl_pkg::CAP_PIND] && !UPSTREAM)
               pind_r <= wdata[slot_ctl_pkg::PIND_LO +: 2];
            if (slot_capabilities_r[slot_ctl_pkg::CAP_PWRCTL])
               pwr_r <= wdata[slot_ctl_pkg::PWR_CTL];
            if (slot_capabilities_r[slot_ctl_pkg::CAP_ILOCK])
               ilock_r <= wdata[slot_ctl_pkg::ILOCK_CTL];
         end
      end
   end

   // read view of slot_control
   always_comb begin
      ctl_view = {3'h0, ctl_r & ctl_wmask};
      ctl_view[slot_ctl_pkg::ATTN_LO +: 2] =
         slot_capabilities_r[slot_ctl_pkg::CAP_ATTN] ? attn_r : 2'h0;
      ctl_view[slot_ctl_pkg::PIND_LO +: 2] =
         slot_capabilities_r[slot_ctl_pkg::CAP_PIND] ? pind_r : 2'h0;
      ctl_view[slot_ctl_pkg::PWR_CTL] =
         slot_capabilities_r[slot_ctl_pkg::CAP_PWRCTL] & pwr_r;
      ctl_view[slot_ctl_pkg::ILOCK_CTL] = 1'b0;
   end

   // command handshake: request held until ack, then wait for ack low
   always_comb begin
      cmd_nxt = cmd_r;
      cc_set = 1'b0;
      case (cmd_r)
         CMD_IDLE: begin
            if (ctl_wr)
               cmd_nxt = CMD_REQ;
         end
         CMD_REQ: begin
            if (lvl[6])
               cmd_nxt = CMD_DROP;
         end
         CMD_DROP: begin
            if (!lvl[6]) begin
               if (pend_r || ctl_wr) begin
                  cmd_nxt = CMD_REQ;
               end else begin
                  cmd_nxt = CMD_IDLE;
                  cc_set = 1'b1;
               end
            end
         end
         default: cmd_nxt = CMD_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_r <= CMD_IDLE;
         req_r <= 1'b0;
      end else begin
         cmd_r <= cmd_nxt;
         req_r <= (cmd_nxt == CMD_REQ);
      end
   end

   // a write during a running command is folded into a repeat of it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
      end else if (cmd_r == CMD_DROP && !lvl[6]) begin
         pend_r <= 1'b0;
      end else if (ctl_wr && cmd_r != CMD_IDLE) begin
         pend_r <= 1'b1;
      end
   end

   // sticky events; a set in the clearing cycle wins
   always_comb begin
      sts_set = '0;
      sts_set[slot_ctl_pkg::ST_BTN] = rise[0];
      sts_set[slot_ctl_pkg::ST_PF] = rise[1];
      sts_set[slot_ctl_pkg::ST_LATCH] = chg[2];
      sts_set[slot_ctl_pkg::ST_PRES] = chg[3];
      sts_set[slot_ctl_pkg::ST_CC] = cc_set;
      sts_set[slot_ctl_pkg::ST_LINK] = chg[5];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sts_r <= slot_ctl_pkg::STS_RST;
      end else if (wr && addr == slot_ctl_pkg::STS_OFS) begin
         sts_r <= (sts_r & ~wdata[15:0]) | sts_set;
      end else begin
         sts_r <= sts_r | sts_set;
      end
   end

   always_comb begin
      sts_view = sts_r & slot_ctl_pkg::STS_STICKY;
      sts_view[slot_ctl_pkg::ST_LATCH_ST] = lvl[2];
      sts_view[slot_ctl_pkg::ST_PRES_ST] = lvl[3];
      sts_view[slot_ctl_pkg::ST_ILOCK_ST] = lvl[4];
   end

   // each event flag paired with its own enable
   always_comb begin
      evt_en = '0;
      evt_en[slot_ctl_pkg::ST_BTN] = ctl_r[slot_ctl_pkg::BTN_EN];
      evt_en[slot_ctl_pkg::ST_PF] = ctl_r[slot_ctl_pkg::PF_EN];
      evt_en[slot_ctl_pkg::ST_LATCH] =
         ctl_r[slot_ctl_pkg::LATCH_EN];
      evt_en[slot_ctl_pkg::ST_PRES] = ctl_r[slot_ctl_pkg::PRES_EN];
      evt_en[slot_ctl_pkg::ST_CC] = ctl_r[slot_ctl_pkg::CC_EN];
      evt_en[slot_ctl_pkg::ST_LINK] = ctl_r[slot_ctl_pkg::LINK_EN];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_r <= slot_ctl_pkg::MASK_RST;
      end else if (wr && addr == slot_ctl_pkg::MASK_OFS) begin
         mask_r <= wdata[15:0] & slot_ctl_pkg::STS_STICKY;
      end
   end

   // wake ignores the master enable and never follows command done
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hp_irq_r <= 1'b0;
         wake_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         hp_irq_r <= ctl_r[slot_ctl_pkg::MASTER_EN] &&
                     |(sts_r & evt_en);
         wake_r <= |(sts_r & evt_en &
                     ~(16'h0001 << slot_ctl_pkg::ST_CC));
         irq_r <= |(sts_r & mask_r);
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else if (rd) begin
         case (addr)
            slot_ctl_pkg::CAP_OFS: rdata_r <= slot_capabilities_r;
            slot_ctl_pkg::CTL_OFS: rdata_r <= {16'h0000, ctl_view};
            slot_ctl_pkg::STS_OFS: rdata_r <= {16'h0000, sts_view};
            slot_ctl_pkg::MASK_OFS: rdata_r <= {16'h0000, mask_r};
            default: rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign rdata = rdata_r;
   assign attention_indicator_ctl = attn_r;
   assign power_indicator_ctl = pind_r;
   assign slot_power_ctl = pwr_r;
   assign interlock_toggle_ctl = ilock_r;
   assign act_req = req_r;
   assign hp_irq = hp_irq_r;
   assign wake = wake_r;
   assign irq = irq_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_cmd_write;
      ctl_wr && cmd_r == CMD_IDLE;
   endsequence

   sequence s_ack_cycle;
      lvl[6] ##1 !lvl[6];
   endsequence

   a_btn_wake: assert property (
      (sts_r[slot_ctl_pkg::ST_BTN] && ctl_r[slot_ctl_pkg::BTN_EN])
      |=> wake)
      else $error("enabled button event gave no wake");
   a_pf_gate: assert property (
      (sts_r[slot_ctl_pkg::ST_PF] && ctl_r[slot_ctl_pkg::PF_EN] &&
       ctl_r[slot_ctl_pkg::MASTER_EN]) |=> hp_irq)
      else $error("enabled power fault gave no interrupt");
   a_cc_no_wake: assert property (
      ((sts_r & evt_en) == (16'h0001 << slot_ctl_pkg::ST_CC)) |=> !wake)
      else $error("command done caused a wake");
   a_master_gate: assert property (
      !ctl_r[slot_ctl_pkg::MASTER_EN] |=> !hp_irq)
      else $error("interrupt without master enable");
   a_irq_cause: assert property (
      hp_irq |-> $past(ctl_r[slot_ctl_pkg::MASTER_EN] && |(sts_r & evt_en)))
      else $error("interrupt without enabled event");
   a_cap_ro: assert property (
      (ctl_wr && !slot_capabilities_r[slot_ctl_pkg::CAP_BTN])
      |=> $stable(ctl_r[slot_ctl_pkg::BTN_EN]))
      else $error("write reached field without capability");
   a_attn_write: assert property (
      (ctl_wr && slot_capabilities_r[slot_ctl_pkg::CAP_ATTN])
      |=> attention_indicator_ctl == $past(wdata[7:6]))
      else $error("attention indicator not set by write");
   a_attn_zero: assert property (
      !slot_capabilities_r[slot_ctl_pkg::CAP_ATTN] |->
      ctl_view[slot_ctl_pkg::ATTN_LO +: 2] == 2'h0)
      else $error("attention field visible without indicator");
   a_pind_zero: assert property (
      !slot_capabilities_r[slot_ctl_pkg::CAP_PIND] |->
      ctl_view[slot_ctl_pkg::PIND_LO +: 2] == 2'h0)
      else $error("power indicator field visible without indicator");
   a_pwr_write: assert property (
      (ctl_wr && slot_capabilities_r[slot_ctl_pkg::CAP_PWRCTL])
      |=> slot_power_ctl == $past(wdata[slot_ctl_pkg::PWR_CTL]))
      else $error("slot power not set by write");
   a_ilock_read: assert property (
      (rd && addr == slot_ctl_pkg::CTL_OFS) |=> !rdata[slot_ctl_pkg::ILOCK_CTL])
      else $error("interlock bit read as one");
   a_cmd_issue: assert property (
      s_cmd_write |=> act_req ##0 !sts_r[slot_ctl_pkg::ST_CC] ||
      $past(sts_r[slot_ctl_pkg::ST_CC]))
      else $error("command write did not request");
   a_cc_late: assert property (
      (s_ack_cycle ##0 (cmd_r == CMD_DROP && !pend_r && !ctl_wr))
      |=> sts_r[slot_ctl_pkg::ST_CC])
      else $error("command ended without completion");
   a_btn_set: assert property (
      rise[0] |=> sts_r[slot_ctl_pkg::ST_BTN])
      else $error("button press lost");
endmodule

// file: tb/slot_hw_model.sv
// slot hardware model: command handshake and interlock mechanism
`timescale 1ns/10ps
module slot_hw_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // commands from the slot controller, and slow from the testbench
   input wire logic act_req,
   input wire logic interlock_toggle_ctl,
   input wire logic slow,
   // answers to the slot controller
   output logic act_ack,
   output logic ilock_engaged
);
   logic [7:0] wait_r;

   // ack follows req after a delay, so done waits for the hardware
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 8'h00;
         act_ack <= 1'b0;
      end else if (act_req != act_ack) begin
         if (wait_r >= (slow ? 8'h06 : 8'h00)) begin
            act_ack <= act_req;
            wait_r <= 8'h00;
         end else begin
            wait_r <= wait_r + 8'h01;
         end
      end
   end

   // each toggle pulse flips the interlock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ilock_engaged <= 1'b0;
      end else if (interlock_toggle_ctl) begin
         ilock_engaged <= !ilock_engaged;
      end
   end
endmodule

// file: tb/hot_plug_slot_control_tb_top.sv
// self-checking testbench for the slot control register bank
`timescale 1ns/10ps
module hot_plug_slot_control_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic btn = 1'b0;
   logic pf = 1'b0;
   logic latch = 1'b0;
   logic pres = 1'b0;
   logic link = 1'b0;
   logic slow = 1'b0;
   logic ack, ilock, tog, act_req, spwr, hp_irq, wake, irq;
   logic [1:0] attn, pind, up_pind;
   logic [31:0] rdata;
   int bad_count = 0;
   int check_count = 0;

   always #5 mclk = !mclk;

   slot_ctl DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .btn_in(btn), .pwr_fault_in(pf),
      .latch_open_in(latch), .present_in(pres), .ilock_engaged_in(ilock),
      .link_up_in(link), .act_ack_in(ack), .attention_indicator_ctl(attn),
      .power_indicator_ctl(pind), .slot_power_ctl(spwr),
      .interlock_toggle_ctl(tog), .act_req(act_req), .hp_irq(hp_irq),
      .wake(wake), .irq(irq));

   // upstream flavour only watched for its power indicator
   slot_ctl #(.UPSTREAM(1'b1)) DUT_UP (.mclk(mclk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(),
      .btn_in(btn), .pwr_fault_in(pf), .latch_open_in(latch),
      .present_in(pres), .ilock_engaged_in(1'b0), .link_up_in(link),
      .act_ack_in(1'b0), .attention_indicator_ctl(),
      .power_indicator_ctl(up_pind), .slot_power_ctl(),
      .interlock_toggle_ctl(), .act_req(), .hp_irq(), .wake(), .irq());

   slot_hw_model u_hw (.mclk(mclk), .rst_n(rst_n), .act_req(act_req),
      .interlock_toggle_ctl(tog), .slow(slow), .act_ack(ack),
      .ilock_engaged(ilock));

   task automatic stop_test;
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd_reg(a, v);
      chk(v, exp);
   endtask

   task automatic settle;
      repeat (4) @(negedge mclk);
   endtask

   // one control write, then poll for done; keep leaves the done flag set
   task automatic wr_cmd(input logic [31:0] d, input bit keep);
      logic [31:0] v;
      wr_reg(slot_ctl_pkg::CTL_OFS, d);
      rd_reg(slot_ctl_pkg::STS_OFS, v);
      chk(32'(v[4]), 32'h0);
      for (int i = 0; i < 40 && v[4] !== 1'b1; i++) begin
         rd_reg(slot_ctl_pkg::STS_OFS, v);
      end
      chk(32'(v[4]), 32'h1);
      settle();
      if (!keep) begin
         wr_reg(slot_ctl_pkg::STS_OFS, 32'h10);
      end
   endtask

   task automatic t_reset;
      chk(32'(attn), 32'h3);
      chk(32'(pind), 32'h1);
      chk(32'({spwr, hp_irq, wake, irq}), 32'h0);
      rd_chk(slot_ctl_pkg::CAP_OFS, 32'h0);
      rd_chk(slot_ctl_pkg::CTL_OFS, 32'h0);
      wr_cmd(32'hFFFF, 1'b0);
      rd_chk(slot_ctl_pkg::CTL_OFS, 32'h1000);
      chk(32'(attn), 32'h3);
   endtask

   task automatic t_cmd_irq;
      wr_reg(slot_ctl_pkg::CAP_OFS, 32'hFFFF_FFFF);
      rd_chk(slot_ctl_pkg::CAP_OFS, 32'h0002_005F);
      slow <= 1'b1;
      wr_cmd(32'h0030, 1'b1);
      chk(32'({hp_irq, wake}), 32'h2);
      wr_reg(slot_ctl_pkg::STS_OFS, 32'h10);
      settle();
      chk(32'(hp_irq), 32'h0);
      slow <= 1'b0;
   endtask

   task automatic t_ind;
      logic [31:0] d;
      for (int v = 0; v < 4; v++) begin
         d = (32'(v) << 8) | (32'(v) << 6) | (32'(v & 1) << 10);
         slow <= v[1];
         wr_cmd(d, 1'b0);
         chk(32'(attn), 32'(v));
         chk(32'(pind), 32'(v));
         chk(32'(spwr), 32'(v & 1));
         chk(32'(up_pind), 32'h1);
         rd_chk(slot_ctl_pkg::CTL_OFS, d);
      end
      wr_reg(slot_ctl_pkg::CAP_OFS, 32'h0002_0047);
      rd_chk(slot_ctl_pkg::CTL_OFS, 32'h400);
      wr_reg(slot_ctl_pkg::CAP_OFS, 32'h0002_005F);
   endtask

   task automatic t_ilock;
      logic [31:0] v;
      wr_cmd(32'h0800, 1'b0);
      rd_reg(slot_ctl_pkg::STS_OFS, v);
      chk(32'(v[7]), 32'h1);
      rd_chk(slot_ctl_pkg::CTL_OFS, 32'h0);
      wr_cmd(32'h0000, 1'b0);
      rd_reg(slot_ctl_pkg::STS_OFS, v);
      chk(32'(v[7]), 32'h1);
      wr_cmd(32'h0800, 1'b0);
      rd_reg(slot_ctl_pkg::STS_OFS, v);
      chk(32'(v[7]), 32'h0);
   endtask

   task automatic t_events;
      logic [31:0] v;
      int b;
      wr_cmd(32'h100F, 1'b0);
      for (int i = 0; i < 4; i++) begin
         b = (i == 3) ? 8 : i + 1;
         @(posedge mclk);
         case (i)
            0: pf <= 1'b1;
            1: latch <= 1'b1;
            2: pres <= 1'b1;
            default: link <= 1'b1;
         endcase
         repeat (8) @(posedge mclk);
         rd_reg(slot_ctl_pkg::STS_OFS, v);
         chk(32'(v[b]), 32'h1);
         chk(32'({wake, hp_irq}), 32'h2);
         wr_reg(slot_ctl_pkg::STS_OFS, 32'h1 << b);
         settle();
         chk(32'(wake), 32'h0);
      end
   endtask

   task automatic t_button;
      logic [31:0] v;
      wr_cmd(32'h100E, 1'b0);
      @(posedge mclk);
      btn <= 1'b1;
      repeat (8) @(posedge mclk);
      btn <= 1'b0;
      rd_reg(slot_ctl_pkg::STS_OFS, v);
      chk(32'(v[0]), 32'h1);
      chk(32'({wake, hp_irq}), 32'h0);
      wr_cmd(32'h100F, 1'b0);
      chk(32'({wake, hp_irq}), 32'h2);
      wr_cmd(32'h102F, 1'b0);
      chk(32'(hp_irq), 32'h1);
      wr_reg(slot_ctl_pkg::MASK_OFS, 32'h1);
      settle();
      chk(32'(irq), 32'h1);
      rd_chk(slot_ctl_pkg::MASK_OFS, 32'h1);
      wr_reg(slot_ctl_pkg::MASK_OFS, 32'h0);
      settle();
      chk(32'(irq), 32'h0);
      wr_reg(slot_ctl_pkg::STS_OFS, 32'h1);
      settle();
      chk(32'({wake, hp_irq}), 32'h0);
      rd_chk(12'h100, 32'h0);
      wr_reg(slot_ctl_pkg::CAP_OFS, 32'h0);
      rd_chk(slot_ctl_pkg::CTL_OFS, 32'h1000);
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_cmd_irq();
      t_ind();
      t_ilock();
      t_events();
      t_button();
      stop_test();
   end

   // the whole run needs well under 10000 cycles
   initial begin
      #500000;
      bad_count++;
      stop_test();
   end
endmodule
